// ### board_test_mode_control_bench.sv
// Testbench for the test mode block
`timescale 1ns/10ps
`default_nettype none
module board_test_mode_control_bench;
  logic clk = 0, rstn = 0, ten = 0, msel = 0, good = 0, nd, tm;
  logic [127:0] ch = 0;
  logic [71:0] fe = 0, pe;
  logic [65:0] fo = 0, po;
  logic [7:0] st;
  logic [1:0] tf;
  logic [141:0] q[$];
  logic [141:0] x;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  bit [31:0] s = 33447;
  always #4 clk = ~clk;
  btm_ate_model btm_ate_model_inst (.good_in(good), .strap_out(st));
  btm_test_ctrl btm_test_ctrl_inst (.sys_clk_in(clk), .rstn_in(rstn), .test_en_in(ten),
    .strap_in(st), .mode_sel_in(msel), .chain_in(ch), .func_even_in(fe), .func_odd_in(fo),
    .nand_out(nd), .pin_even_out(pe), .pin_odd_out(po), .test_mode_out(tm), .test_func_out(tf));
  function bit [31:0] rnd();
    s ^= s << 13; s ^= s >> 17; s ^= s << 5; return s;
  endfunction
  function bit nt(bit [127:0] c);
    nt = 1;
    for (int i = 0; i < 128; i++) nt = ~(nt & c[i]);
  endfunction
  function logic [137:0] pins(logic [1:0] f);
    if (f == 2'h2) return {{72{1'b1}}, {66{1'b0}}};
    if (f == 2'h3) return {{72{1'b0}}, {66{1'b1}}};
    return {fe, fo};
  endfunction
  task chk(logic [3:0] e, logic [3:0] g);
    cmp_count++;
    if (g !== e) begin fail_count++; $display("ERROR %0t got %h want %h", $time, g, e); end
  endtask
  task chk_pins(logic [137:0] e, logic [137:0] g);
    cmp_count++;
    if (g !== e) begin fail_count++; $display("ERROR %0t pins got %h want %h", $time, g, e); end
  endtask
  always @(posedge clk) begin
    #1;
    if (q.size() > 0) begin
      x = q.pop_front();
      chk(x[141:138], {tm, tf, nd});
      chk_pins(x[137:0], {pe, po});
    end
  end
  task end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 400) begin fail_count++; end_of_test; end
  task step(bit g, bit t, bit m, logic [3:0] e);
    @(negedge clk); good = g; ten = t; msel = m; ch = {rnd(), rnd(), rnd(), rnd()};
    fe = 72'({rnd(), rnd(), rnd()});
    fo = 66'({rnd(), rnd(), rnd()});
    repeat (3) @(negedge clk);
    q.push_back({e[3:1], ((e[2:1] == 2'h1) ? nt(ch) : 1'h0), pins(e[2:1])});
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rstn = 1;
    for (int i = 0; i < 6; i++) begin
      step(1, 1, 0, 4'hA);
      step(1, 0, i[0], {2'h3, i[0], 1'h0});
    end
    step(0, 1, 0, 4'h0);
    step(1, 0, 1, 4'h0);
    step(1, 1, 0, 4'hA);
    repeat (2) @(negedge clk);
    end_of_test;
  end
endmodule
`default_nettype wire

// ### btm_ate_model.sv
// Tester model that sets up the strap pattern
`timescale 1ns/10ps
`default_nettype none
module btm_ate_model (input wire logic good_in, output logic [7:0] strap_out);
  assign strap_out = good_in ? 8'hC0 : 8'h80;
endmodule
`default_nettype wire

// ### btm_checker.sv
// Assertions on the test mode ports
`timescale 1ns/10ps
`default_nettype none
module btm_checker #(parameter EVEN_WIDTH = 72, ODD_WIDTH = 66) (
  input wire logic sys_clk_in, rstn_in, test_en_in, mode_sel_in, test_mode_out, nand_out,
  input wire logic [7:0] strap_in,
  input wire logic [1:0] test_func_out,
  input wire logic [EVEN_WIDTH-1:0] pin_even_out,
  input wire logic [ODD_WIDTH-1:0] pin_odd_out);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence rise_s; $rose(test_en_in); endsequence
  sequence good_rise_s; rise_s ##0 strap_in == 8'hC0; endsequence
  sequence bad_rise_s; rise_s ##0 strap_in != 8'hC0; endsequence
  a_strap_entry: assert property (good_rise_s |-> ##2 test_mode_out)
    else $error("no entry");
  a_strap_refused: assert property (bad_rise_s |-> ##2 !test_mode_out)
    else $error("bad entry");
  a_drive_high: assert property (test_func_out == 2'h2 |-> !pin_odd_out && &pin_even_out)
    else $error("drive high");
  a_drive_low: assert property (test_func_out == 2'h3 |-> !pin_even_out && &pin_odd_out)
    else $error("drive low");
  a_normal_func: assert property (!test_mode_out |-> test_func_out == 2'h0)
    else $error("function outside test mode");
  a_nand_hold: assert property (test_func_out == 2'h1 |-> $past(test_en_in))
    else $error("nand without enable");
  a_drive_pick: assert property (test_func_out[1] |-> test_func_out[0] == $past(mode_sel_in))
    else $error("drive variant");
  a_nand_quiet: assert property (test_func_out != 2'h1 |-> !nand_out)
    else $error("chain output outside nand mode");
endmodule
bind btm_test_ctrl btm_checker #(.EVEN_WIDTH(EVEN_WIDTH), .ODD_WIDTH(ODD_WIDTH)) btm_checker_inst
  (.sys_clk_in, .rstn_in, .test_en_in, .mode_sel_in, .test_mode_out, .nand_out, .strap_in,
  .test_func_out, .pin_even_out, .pin_odd_out);
`default_nettype wire

// ### btm_map.vh
// Constants for the board test mode control block
`ifndef BTM_MAP_VH
`define BTM_MAP_VH
`define BTM_NAND_WIDTH    128
`define BTM_EVEN_WIDTH    72
`define BTM_ODD_WIDTH     66
`define BTM_STRAP_WIDTH   8
// Strap pattern: bits 7:6 must be high, bits 5:0 low
`define BTM_STRAP_MATCH   8'hC0
`define BTM_STRAP_HI_POS  6
`define BTM_MODE_NAND     2'h1
`define BTM_MODE_DRV_HIGH 2'h2
`define BTM_MODE_DRV_LOW  2'h3
`define BTM_MODE_NORMAL   2'h0
`endif

// ### btm_test_ctrl.v
// Board test mode control: strap capture, NAND tree chain and drive patterns
//
// Behaviour
// - Entry needs strap bits 7:6 high and strap bits 5:0 low, set up before test enable rises.
// - The strap pattern is captured on every rising edge of test enable; a match enters test mode.
// - A captured pattern that does not match leaves the device in normal operation.
// - Test mode offers only NAND tree, drive-high and drive-low functions.
// - In test mode the NAND tree runs while test enable stays high.
// - The NAND tree chains all listed inputs from the start input to a single output.
// - In test mode with test enable low a drive test runs, chosen by the mode-select strap.
// - Drive-high drives odd-numbered outputs low and even-numbered outputs high.
// - Drive-low (mode-select high) drives even-numbered outputs low and odd-numbered high.
`timescale 1ns/10ps
`default_nettype none
`include "btm_map.vh"
module btm_test_ctrl #(
  parameter NAND_WIDTH = `BTM_NAND_WIDTH,
  parameter EVEN_WIDTH = `BTM_EVEN_WIDTH,
  parameter ODD_WIDTH  = `BTM_ODD_WIDTH
) (
  // Clock and reset
  input  wire                  sys_clk_in,
  input  wire                  rstn_in,
  // Tester pins
  input  wire                  test_en_in,
  input  wire [`BTM_STRAP_WIDTH-1:0] strap_in,
  input  wire                  mode_sel_in,
  input  wire [NAND_WIDTH-1:0] chain_in,
  // Functional output values from the rest of the chip
  input  wire [EVEN_WIDTH-1:0] func_even_in,
  input  wire [ODD_WIDTH-1:0]  func_odd_in,
  // Pin results
  output reg                   nand_out,
  output reg  [EVEN_WIDTH-1:0] pin_even_out,
  output reg  [ODD_WIDTH-1:0]  pin_odd_out,
  output reg                   test_mode_out,
  output reg  [1:0]            test_func_out
);

  // Entry states of the controller
  localparam [0:0] ST_NORMAL     = 1'b0;
  localparam [0:0] ST_TEST       = 1'b1;

  // Function codes as reported on test_func_out
  localparam [1:0] FUNC_NORMAL   = `BTM_MODE_NORMAL;
  localparam [1:0] FUNC_NAND     = `BTM_MODE_NAND;
  localparam [1:0] FUNC_DRV_HIGH = `BTM_MODE_DRV_HIGH;
  localparam [1:0] FUNC_DRV_LOW  = `BTM_MODE_DRV_LOW;

  reg                   test_en_q;
  reg  [0:0]            state;
  reg  [0:0]            next_state;
  reg  [1:0]            next_func;
  reg                   next_nand;
  wire                  test_en_rise;
  wire                  strap_ok;
  wire                  in_test;
  wire [NAND_WIDTH:0]   chain;
  wire [EVEN_WIDTH-1:0] next_even;
  wire [ODD_WIDTH-1:0]  next_odd;

  // True when the sampled straps form the entry pattern
  function strap_match(input [`BTM_STRAP_WIDTH-1:0] straps);
    strap_match = (straps == `BTM_STRAP_MATCH);
  endfunction

  // True for the two drive test functions
  function is_drive(input [1:0] func);
    is_drive = (func == FUNC_DRV_HIGH) || (func == FUNC_DRV_LOW);
  endfunction

  // Driven level: odd pins low in drive-high, high in drive-low
  function drive_level(input [1:0] func, input odd_pin);
    case (func)
      FUNC_DRV_HIGH: drive_level = ~odd_pin;
      FUNC_DRV_LOW:  drive_level = odd_pin;
      default:       drive_level = 1'b0;
    endcase
  endfunction

  assign in_test      = (state == ST_TEST);
  assign test_en_rise = test_en_in & ~test_en_q;
  assign strap_ok     = strap_match(strap_in);

  // History resets low, so a pin already high at release counts as a rise
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      test_en_q <= 1'b0;
    end else begin
      test_en_q <= test_en_in;
    end
  end

  // Entry is re-evaluated at every rising edge of test enable
  always @* begin
    next_state = state;
    case (state)
      ST_NORMAL: begin
        if (test_en_rise && strap_ok) begin
          next_state = ST_TEST;
        end
      end
      ST_TEST: begin
        if (test_en_rise && !strap_ok) begin
          next_state = ST_NORMAL;
        end
      end
      default: begin
        next_state = ST_NORMAL;
      end
    endcase
  end

  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= ST_NORMAL;
    end else begin
      state <= next_state;
    end
  end

  // Serial NAND chain; an input flip changes its stage only while the previous stage output is high
  assign chain[0] = 1'b1;
  genvar g;
  generate
    for (g = 0; g < NAND_WIDTH; g = g + 1) begin : g_chain
      assign chain[g+1] = ~(chain[g] & chain_in[g]);
    end
  endgenerate

  // Mode selection is live, not latched at entry
  always @* begin
    if (!in_test) begin
      next_func = FUNC_NORMAL;
    end else if (test_en_in) begin
      next_func = FUNC_NAND;
    end else if (mode_sel_in) begin
      next_func = FUNC_DRV_LOW;
    end else begin
      next_func = FUNC_DRV_HIGH;
    end
  end

  // Chain result shows only in NAND mode
  always @* begin
    if (next_func == FUNC_NAND) begin
      next_nand = chain[NAND_WIDTH];
    end else begin
      next_nand = 1'b0;
    end
  end

  genvar e;
  generate
    for (e = 0; e < EVEN_WIDTH; e = e + 1) begin : g_even
      assign next_even[e] = is_drive(next_func) ?
                            drive_level(next_func, 1'b0) : func_even_in[e];
    end
  endgenerate

  genvar o;
  generate
    for (o = 0; o < ODD_WIDTH; o = o + 1) begin : g_odd
      assign next_odd[o] = is_drive(next_func) ?
                           drive_level(next_func, 1'b1) : func_odd_in[o];
    end
  endgenerate

  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      test_mode_out <= 1'b0;
    end else begin
      test_mode_out <= in_test;
    end
  end

  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      test_func_out <= FUNC_NORMAL;
    end else begin
      test_func_out <= next_func;
    end
  end

  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      nand_out <= 1'b0;
    end else begin
      nand_out <= next_nand;
    end
  end

  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_even_out <= {EVEN_WIDTH{1'b0}};
    end else begin
      pin_even_out <= next_even;
    end
  end

  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_odd_out <= {ODD_WIDTH{1'b0}};
    end else begin
      pin_odd_out <= next_odd;
    end
  end

endmodule
`default_nettype wire
